// [tb/gsx_chain_model.sv]
// Purpose: Behavioural chain of eight output parts and eight input parts, 64 pins.
// Assumes: Rising shift clock shifts both part types; load latches and captures.
// Notes: Input parts have no reset, so the first frame after start returns junk.
`timescale 1ns/1ps
`default_nettype none

module gsx_chain_model (
    // Serial lines from the controller
    input wire logic shift_clock_i,
    input wire logic load_i,
    input wire logic reset_n_i,
    input wire logic data_i,
    // Serial line back to the controller
    output logic data_o,
    // Parallel pins
    input wire logic [63:0] pins_i,
    output logic [63:0] pins_o,
    // Shift clock rises seen before the last load
    output int rises_o
);
    logic [63:0] sipo_q = '0;  // Output parts' shift stages
    logic [63:0] piso_q = '0;  // Input parts' shift stages
    logic [63:0] latch_q = '0; // Output parts' parallel latches
    int cnt_q = 0;

    // Far end bit of the input chain drives the data-in line
    assign data_o = piso_q[63];
    assign pins_o = latch_q;

    // Shift on rising clock, latch and capture on load
    always @(posedge shift_clock_i or posedge load_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            // Clear clears the output shift stages and the rise count; latches and input stages keep their values
            sipo_q <= '0;
            cnt_q <= 0;
        end else if (load_i) begin
            latch_q <= sipo_q;
            piso_q <= pins_i;
            rises_o <= cnt_q;
            cnt_q <= 0;
        end else begin
            sipo_q <= {sipo_q[62:0], data_i};
            // Tail feeds back the inverted far-end bit so stale bits never look valid
            piso_q <= {piso_q[62:0], ~piso_q[63]};
            cnt_q <= cnt_q + 1;
        end
    end
endmodule : gsx_chain_model

`default_nettype wire

// [tb/gsx_expander_bench.sv]
// Purpose: Self-checking bench for the serial expander controller.
// Assumes: Link clock 48 ns free running, system clock 10 ns.
// Notes: Output words are noted in a queue and checked when each frame ends.
`timescale 1ns/1ps
`default_nettype none

module gsx_expander_bench;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic clk_sys_i = 1'b0;
    logic clk_link_i = 1'b0;
    logic srst_i = 1'b1;
    logic start = 1'b0;
    logic out_valid = 1'b0;
    logic out_ready;
    logic [63:0] out_data = '0;
    logic in_valid;
    logic [63:0] in_data;
    logic dout, load, rst_n, sclk, din;
    logic [63:0] pins_drv, pins_got, prev_pins;
    int rises;
    bit have_prev = 0;
    int error_cnt = 0;
    int comparisons = 0;
    logic [63:0] exp_out[$];

    // ------------------------------------------------------------------
    // Clocks: link clock offset by 7 ns; edges still coincide every 120 ns
    // ------------------------------------------------------------------
    initial forever #5 clk_sys_i = ~clk_sys_i;
    initial begin
        #7;
        forever #24 clk_link_i = ~clk_link_i;
    end

    gsx_expander dut (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .clk_link_i(clk_link_i),
        .controller_start_bit_i(start),
        .out_valid_i(out_valid), .out_ready_o(out_ready), .out_data_i(out_data),
        .in_valid_o(in_valid), .in_data_o(in_data),
        .expander_data_out_o(dout), .expander_serial_load_o(load),
        .expander_serial_reset_n_o(rst_n), .expander_shift_clock_o(sclk),
        .expander_data_in_i(din)
    );

    gsx_chain_model chain (
        .shift_clock_i(sclk), .load_i(load), .reset_n_i(rst_n), .data_i(dout),
        .data_o(din), .pins_i(pins_drv), .pins_o(pins_got), .rises_o(rises)
    );

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    // Offer one word; it is only driven when the queue has room
    task automatic push(input logic [63:0] w, output bit ok);
        @(negedge clk_sys_i);
        ok = (out_ready === 1'b1);
        if (ok) begin
            out_valid = 1'b1;
            out_data = w;
            exp_out.push_back(w);
            @(negedge clk_sys_i);
            out_valid = 1'b0;
        end
    endtask : push

    // Reset, load and shift clock must stay low while stopped
    task automatic quiet(input int n);
        logic bad;
        bad = 1'b0;
        repeat (n) begin
            @(negedge clk_sys_i);
            bad |= (rst_n !== 1'b0) | (load !== 1'b0) | (sclk !== 1'b0);
        end
        cmp({63'h0, bad}, 64'h0);
    endtask : quiet

    // Bounded wait until every noted word has come back
    task automatic drain();
        int i;
        for (i = 0; i < 40000 && exp_out.size() > 0; i++) @(negedge clk_sys_i);
        cmp(64'(exp_out.size()), 64'h0);
    endtask : drain

    // ------------------------------------------------------------------
    // Monitor: each frame end takes the oldest noted word
    // ------------------------------------------------------------------
    always @(negedge clk_sys_i) begin
        if (in_valid === 1'b1) begin
            if (exp_out.size() == 0) cmp(64'h1, 64'h0);
            else cmp(pins_got, exp_out.pop_front());
            cmp(64'(rises), 64'h40);
            if (have_prev) cmp(in_data, prev_pins);
            prev_pins = pins_drv;
            have_prev = 1;
            pins_drv = {$urandom, $urandom};
        end
    end

    // Watchdog sized well above sixteen frames
    initial begin
        #2ms;
        error_cnt++;
        tally_and_finish();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        int acc;
        bit ok;
        void'($urandom(9520));
        pins_drv = {$urandom, $urandom};
        // Reset long enough to reach the link side too
        repeat (20) @(negedge clk_sys_i);
        srst_i = 1'b0;
        // Stopped: fill the queue until it refuses
        acc = 0;
        repeat (12) begin
            push({$urandom, $urandom}, ok);
            acc += int'(ok);
        end
        cmp(64'(acc == 8 || acc == 9), 64'h1);
        quiet(100);
        // Start: queued words run as frames
        start = 1'b1;
        repeat (30) @(negedge clk_sys_i);
        cmp({63'h0, rst_n}, 64'h1);
        repeat (4) push({$urandom, $urandom}, ok);
        drain();
        // Boundary patterns back to back
        push(64'h0, ok);
        push(64'hFFFFFFFFFFFFFFFF, ok);
        push(64'h8000000000000001, ok);
        drain();
        // Stop again: a new word must wait, reset, load and clock park
        start = 1'b0;
        repeat (30) @(negedge clk_sys_i);
        push(64'hA5A5A5A5A5A5A5A5, ok);
        quiet(400);
        cmp(64'(exp_out.size()), 64'(ok));
        tally_and_finish();
    end
endmodule : gsx_expander_bench

`default_nettype wire

// [verilog/gsx_expander.sv]
// Purpose: Serial GPIO expander controller with output queue and link domain.
// Assumes: Link clock is free running; start level comes from the control logic.
// Notes: Returned input word is the one captured by the previous frame's load.
//
// Notes on behaviour
// - Pins grouped eight per external shift register
// - Chain up to eight parts, sixty-four pins
// - Serial reset held low until start set
// - Load stays low until start set
// - Shift clock static until start set
// - Four serial outputs, one serial data input
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Synchronous FIFO
// ----------------------------------------------------------------------
module gsx_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int unsigned PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];          // Word storage
    logic [PW-1:0] wr_q, wr_d;              // Write pointer
    logic [PW-1:0] rd_q, rd_d;              // Read pointer
    logic [PW:0] cnt_q, cnt_d;              // Words held
    logic push, pop;

    // Honest flags straight from the count
    assign in_ready_o = (cnt_q != (PW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem[rd_q];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // Pointer and count update
    always_comb begin
        wr_d = push ? ((wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
        rd_d = pop ? ((rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // Registers; storage needs no reset
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem[wr_q] <= in_data_i;
        end
        if (srst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end
endmodule : gsx_fifo

// ----------------------------------------------------------------------
// Controller top
// ----------------------------------------------------------------------
module gsx_expander (
    // System clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Link clock
    input wire logic clk_link_i,
    // Control
    input wire logic controller_start_bit_i,
    // Output word queue
    input wire logic out_valid_i,
    output logic out_ready_o,
    input wire logic [gsx_pkg::CHAIN_BITS-1:0] out_data_i,
    // Captured input word
    output logic in_valid_o,
    output logic [gsx_pkg::CHAIN_BITS-1:0] in_data_o,
    // Expander pins
    output logic expander_data_out_o,
    output logic expander_serial_load_o,
    output logic expander_serial_reset_n_o,
    output logic expander_shift_clock_o,
    input wire logic expander_data_in_i
);
    localparam int unsigned NB = gsx_pkg::CHAIN_BITS;

    // ------------------------------------------------------------------
    // System side: queue and handshake toward the link
    // ------------------------------------------------------------------
    logic fq_valid, fq_ready;
    logic [NB-1:0] fq_data;
    logic req_q, req_d;                     // Toggles once per word handed over
    logic [NB-1:0] xfer_q, xfer_d;          // Held stable while a word is in flight
    logic ack_s1_q, ack_s2_q;               // Ack synchroniser
    logic [NB-1:0] in_data_q, in_data_d;
    logic in_valid_q, in_valid_d;
    logic busy;
    logic ack_s3_q;                         // Delayed copy for edge detection
    logic ack_sync_edge;                    // One pulse per ack toggle

    gsx_fifo #(
        .WIDTH(NB),
        .DEPTH(gsx_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .in_valid_i(out_valid_i),
        .in_ready_o(out_ready_o),
        .in_data_i(out_data_i),
        .out_valid_o(fq_valid),
        .out_ready_i(fq_ready),
        .out_data_o(fq_data)
    );

    logic ack_q;                            // Link-side ack toggle
    logic [NB-1:0] cap_q;                   // Link-side captured inputs

    // Two-phase handshake: a word is in flight while the toggles differ
    assign busy = (req_q != ack_s2_q);
    assign fq_ready = ~busy;

    // Next values for the system side
    always_comb begin
        req_d = req_q;
        xfer_d = xfer_q;
        in_data_d = in_data_q;
        in_valid_d = 1'b0;
        if (!busy && fq_valid) begin
            // Queue drains only when the link is free; otherwise it fills
            xfer_d = fq_data;
            req_d = ~req_q;
        end
        if (ack_sync_edge) begin
            // Safe to read: the link loaded this word on the edge its ack toggled and holds it until the next load
            in_data_d = cap_q;
            in_valid_d = 1'b1;
        end
    end

    assign ack_sync_edge = ack_s2_q ^ ack_s3_q;

    // System side registers
    always_ff @(posedge clk_sys_i) begin
        ack_s1_q <= ack_q;
        ack_s2_q <= ack_s1_q;
        if (srst_i) begin
            ack_s3_q <= 1'b0;
            req_q <= 1'b0;
            xfer_q <= '0;
            in_data_q <= '0;
            in_valid_q <= 1'b0;
        end else begin
            ack_s3_q <= ack_s2_q;
            req_q <= req_d;
            xfer_q <= xfer_d;
            in_data_q <= in_data_d;
            in_valid_q <= in_valid_d;
        end
    end

    assign in_data_o = in_data_q;
    assign in_valid_o = in_valid_q;

    // ------------------------------------------------------------------
    // Link side: synchronisers
    // ------------------------------------------------------------------
    logic lrst_s1_q, lrst_q;                // Reset brought onto the link clock
    logic st_s1_q, st_q;                    // Start level
    logic rq_s1_q, rq_q;                    // Request toggle
    logic din_s1_q, din_q;                  // Serial data in pin

    // Plain two-stage chains; only the second stage is read
    always_ff @(posedge clk_link_i) begin
        lrst_s1_q <= srst_i;
        lrst_q <= lrst_s1_q;
        st_s1_q <= controller_start_bit_i;
        st_q <= st_s1_q;
        rq_s1_q <= req_q;
        rq_q <= rq_s1_q;
        din_s1_q <= expander_data_in_i;
        din_q <= din_s1_q;
    end

    // ------------------------------------------------------------------
    // Link side: frame engine
    // ------------------------------------------------------------------
    gsx_pkg::gsx_state_t st_q_s, st_d_s;
    logic [1:0] ph_q, ph_d;
    logic [gsx_pkg::BIT_CNT_W-1:0] bit_q, bit_d;
    logic [NB-1:0] sr_q, sr_d;              // Out bits leave MSB first, in bits enter LSB
    logic [NB-1:0] cap_d;
    logic ack_d;
    logic dout_q, dout_d;
    logic sclk_q, sclk_d;
    logic load_q, load_d;
    logic srn_q, srn_d;

    // Next values: one bit every four link cycles, then a one-cycle load
    always_comb begin
        st_d_s = st_q_s;
        ph_d = ph_q;
        bit_d = bit_q;
        sr_d = sr_q;
        cap_d = cap_q;
        ack_d = ack_q;
        dout_d = dout_q;
        sclk_d = gsx_pkg::RST_SHIFT_CLOCK;
        load_d = gsx_pkg::RST_LOAD;
        srn_d = st_q;
        case (st_q_s)
            gsx_pkg::GSX_IDLE: begin
                // Nothing moves before start, so clock and load stay parked
                if (st_q && (rq_q != ack_q)) begin
                    sr_d = xfer_q;
                    ph_d = gsx_pkg::PH_DRIVE;
                    bit_d = '0;
                    dout_d = xfer_q[NB-1];
                    st_d_s = gsx_pkg::GSX_SHIFT;
                end
            end
            gsx_pkg::GSX_SHIFT: begin
                ph_d = ph_q + 2'h1;
                sclk_d = (ph_d >= gsx_pkg::PH_RISE);
                if (ph_d == gsx_pkg::PH_DRIVE) begin
                    dout_d = sr_q[NB-1];
                end
                if (ph_d == gsx_pkg::PH_RISE) begin
                    // Input bit has been stable since the previous rising edge
                    sr_d = {sr_q[NB-2:0], din_q};
                end
                if (ph_q == gsx_pkg::PH_LAST) begin
                    sclk_d = 1'b0;
                    bit_d = bit_q + 1'b1;
                    if (bit_q == gsx_pkg::LAST_BIT) begin
                        st_d_s = gsx_pkg::GSX_LOAD;
                    end
                end
            end
            gsx_pkg::GSX_LOAD: begin
                // Latches the outputs and captures the input pins for the next frame
                load_d = 1'b1;
                cap_d = sr_q;
                ack_d = ~ack_q;
                st_d_s = gsx_pkg::GSX_IDLE;
            end
            default: begin
                st_d_s = gsx_pkg::GSX_IDLE;
            end
        endcase
        if (!st_q) begin
            load_d = gsx_pkg::RST_LOAD;
        end
    end

    // Link side registers
    always_ff @(posedge clk_link_i) begin
        if (lrst_q) begin
            st_q_s <= gsx_pkg::GSX_IDLE;
            ph_q <= '0;
            bit_q <= '0;
            sr_q <= '0;
            cap_q <= '0;
            ack_q <= 1'b0;
            dout_q <= gsx_pkg::RST_DATA_OUT;
            sclk_q <= gsx_pkg::RST_SHIFT_CLOCK;
            load_q <= gsx_pkg::RST_LOAD;
            srn_q <= gsx_pkg::RST_SERIAL_RESET_N;
        end else begin
            st_q_s <= st_d_s;
            ph_q <= ph_d;
            bit_q <= bit_d;
            sr_q <= sr_d;
            cap_q <= cap_d;
            ack_q <= ack_d;
            dout_q <= dout_d;
            sclk_q <= sclk_d;
            load_q <= load_d;
            srn_q <= srn_d;
        end
    end

    assign expander_data_out_o = dout_q;
    assign expander_serial_load_o = load_q;
    assign expander_serial_reset_n_o = srn_q;
    assign expander_shift_clock_o = sclk_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [7:0] rise_cnt_q;                 // Shift clock rises in the current frame
    always_ff @(posedge clk_link_i) begin
        // Idle clear keeps a frame whose load a stop suppressed from skewing the next count
        if (lrst_q || load_q || (st_q_s == gsx_pkg::GSX_IDLE)) begin
            rise_cnt_q <= '0;
        end else if (sclk_d && !sclk_q) begin
            rise_cnt_q <= rise_cnt_q + 8'h01;
        end
    end

    property p_reset_until_start;
        @(posedge clk_link_i) disable iff (lrst_q)
        !$past(st_q) |-> !expander_serial_reset_n_o;
    endproperty
    a_reset_until_start: assert property (p_reset_until_start) else $error("serial reset released early");

    property p_load_low_before_start;
        @(posedge clk_link_i) disable iff (lrst_q)
        (!st_q && st_q_s == gsx_pkg::GSX_IDLE) |=> !expander_serial_load_o;
    endproperty
    a_load_low_before_start: assert property (p_load_low_before_start) else $error("load moved before start");

    property p_clock_static_before_start;
        @(posedge clk_link_i) disable iff (lrst_q)
        (!st_q && st_q_s == gsx_pkg::GSX_IDLE) |=> $stable(expander_shift_clock_o);
    endproperty
    a_clock_static_before_start: assert property (p_clock_static_before_start) else $error("clock toggled before start");

    property p_chain_length;
        @(posedge clk_link_i) disable iff (lrst_q)
        $rose(expander_serial_load_o) |-> rise_cnt_q == 8'h40;
    endproperty
    a_chain_length: assert property (p_chain_length) else $error("frame is not sixty-four bits");

    property p_whole_groups;
        @(posedge clk_link_i) disable iff (lrst_q)
        $rose(expander_serial_load_o) |-> rise_cnt_q[2:0] == 3'h0;
    endproperty
    a_whole_groups: assert property (p_whole_groups) else $error("frame not in groups of eight");

    property p_load_single_pulse;
        @(posedge clk_link_i) disable iff (lrst_q)
        $rose(expander_serial_load_o) |=> !expander_serial_load_o ##1 !expander_serial_load_o;
    endproperty
    a_load_single_pulse: assert property (p_load_single_pulse) else $error("load pulse too long");

    property p_clock_high_two;
        @(posedge clk_link_i) disable iff (lrst_q)
        $rose(expander_shift_clock_o) |-> expander_shift_clock_o[*2] ##1 !expander_shift_clock_o;
    endproperty
    a_clock_high_two: assert property (p_clock_high_two) else $error("shift clock high time wrong");

    property p_data_stable_at_rise;
        @(posedge clk_link_i) disable iff (lrst_q)
        $rose(expander_shift_clock_o) |-> $stable(expander_data_out_o) && $past(!expander_serial_load_o);
    endproperty
    a_data_stable_at_rise: assert property (p_data_stable_at_rise) else $error("data moved at clock rise");

endmodule : gsx_expander

`default_nettype wire

// [verilog/gsx_pkg.sv]
// Purpose: Shared constants for the serial GPIO expander controller.
// Assumes: Chain of discrete shift registers, eight pins per part.
// Notes: Link-side timing is counted in link clock cycles.
`default_nettype none

package gsx_pkg;

    // ------------------------------------------------------------------
    // Chain geometry
    // ------------------------------------------------------------------
    localparam int unsigned PINS_PER_DEVICE = 8;   // Pins on one external part
    localparam int unsigned CHAIN_DEVICES = 8;     // Longest supported chain
    localparam int unsigned CHAIN_BITS = PINS_PER_DEVICE * CHAIN_DEVICES;
    localparam int unsigned BIT_CNT_W = $clog2(CHAIN_BITS);
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = BIT_CNT_W'(CHAIN_BITS - 1);

    // ------------------------------------------------------------------
    // Buffering
    // ------------------------------------------------------------------
    localparam int unsigned FIFO_DEPTH = 8;        // Words queued toward the link

    // ------------------------------------------------------------------
    // Shift clock phases: four link cycles per bit, clock high in the last two
    // ------------------------------------------------------------------
    localparam logic [1:0] PH_DRIVE = 2'h0;        // New data bit presented
    localparam logic [1:0] PH_RISE = 2'h2;         // Shift clock rises, input sampled
    localparam logic [1:0] PH_LAST = 2'h3;         // Final phase of a bit

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic RST_SERIAL_RESET_N = 1'b0;    // Chain held in reset
    localparam logic RST_LOAD = 1'b0;              // Load strobe idle low
    localparam logic RST_SHIFT_CLOCK = 1'b0;       // Shift clock parked low
    localparam logic RST_DATA_OUT = 1'b0;          // Data line parked low

    // ------------------------------------------------------------------
    // Link state machine
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        GSX_IDLE = 3'b001,
        GSX_SHIFT = 3'b010,
        GSX_LOAD = 3'b100
    } gsx_state_t;

endpackage : gsx_pkg

`default_nettype wire
